/* vram_refresh_port_access_test.sv */
// Self-checking bench: controller and requester joined by the link.
// Assumes the constants of vrpa_map.svh and a 250 MHz mclk_i.
`timescale 1ns/1ps
`include "vrpa_map.svh"
module vram_refresh_port_access_test;
  // Clock, reset and programming
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic amode = 1'b1;
  logic wstyle = 1'b0;
  logic rout = 1'b0;
  logic rshort = 1'b1;
  logic [2:0] wst = 3'h0;
  // Requester user side
  logic start_a = 1'b0;
  logic wext = 1'b0;
  logic start_b = 1'b0;
  logic xmode = 1'b1;
  logic rreq = 1'b0;
  logic rclr = 1'b0;
  logic [1:0] bank = 2'h0;
  logic [10:0] row = 11'h0;
  logic [10:0] col = 11'h0;
  // Observed outputs
  logic ras_n, rf_act, pb_act, busy_a, done_a, busy_b, due, gnt;
  logic [10:0] rf_row;
  logic [10:0] lrow;
  logic [10:0] lcol;
  logic [1:0] lbank;
  int err_total = 0;
  int checked = 0;

  // Clock at 4 ns period
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  vrpa_link_if link();
  vrpa_ctrl vrpa_ctrl_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
    .access_mode_i(amode), .wait_style_sel_i(wstyle), .addr_latch_en_i(1'b1),
    .wait_states_i(wst), .refresh_out_mode_i(rout), .refresh_short_i(rshort),
    .ras_n_o(ras_n), .refresh_active_o(rf_act), .port_b_active_o(pb_act),
    .refresh_row_o(rf_row), .lat_bank_o(lbank), .lat_row_o(lrow), .lat_col_o(lcol));
  vrpa_req vrpa_req_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
    .access_mode_i(amode), .wait_style_sel_i(wstyle), .start_a_i(start_a),
    .bank_i(bank), .row_i(row), .col_i(col), .wait_extend_i(wext),
    .busy_a_o(busy_a), .done_a_o(done_a), .start_b_i(start_b), .busy_b_o(busy_b),
    .ext_refresh_mode_i(xmode), .refresh_req_i(rreq), .row_clear_i(rclr),
    .refresh_due_o(due), .granted_b_o(gnt));
  vrpa_link_asserts vrpa_link_asserts_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .chip_sel_n(link.chip_sel_n), .access_req_n(link.access_req_n),
    .second_port_req_n(link.second_port_req_n), .xfer_ack_n(link.xfer_ack_n),
    .second_port_early_ack_n(link.second_port_early_ack_n),
    .refresh_due_n(link.refresh_due_n), .second_port_granted(link.second_port_granted));

  // Wait n edges, then settle past the edge before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // One first-port access; n counts strobe-low cycles before completion shows
  task automatic run_a(input logic m, input logic s, input logic [2:0] w, input logic x,
      input logic [10:0] r, output int n);
    logic done;
    logic waited;
    logic dseen;
    int k;
    done = 1'b0;
    waited = 1'b0;
    dseen = 1'b0;
    n = 0;
    @(posedge mclk_i);
    amode <= m;
    wstyle <= s;
    wst <= w;
    wext <= x;
    row <= r;
    col <= ~r;
    bank <= r[1:0];
    cyc(6);
    @(posedge mclk_i);
    start_a <= 1'b1;
    @(posedge mclk_i);
    start_a <= 1'b0;
    for (k = 0; k < 300 && !done; k++) begin
      // Extension is dropped after a few edges so the access can finish
      @(posedge mclk_i);
      if (k == 4) wext <= 1'b0;
      #1;
      if (link.xfer_ack_n === 1'b0) waited = 1'b1;
      done = s ? (link.xfer_ack_n === 1'b0) : (waited && link.xfer_ack_n === 1'b1);
      if (ras_n === 1'b0 && !done) n++;
    end
    cmp(done, 1'b1, "access completed");
    cmp(n > 0, 1'b1, "ack held off while strobe low");
    cmp(waited | s, 1'b1, "wait shown low");
    cmp(lrow, r, "row latched on strobe");
    cmp(lcol, col, "column latched on strobe");
    cmp(lbank, bank, "bank latched on strobe");
    for (k = 0; k < 20 && ras_n !== 1'b1; k++) begin
      cyc(1);
      if (done_a === 1'b1) dseen = 1'b1;
    end
    cmp(ras_n, 1'b1, "strobe released after request");
    cmp(dseen, 1'b1, "requester done pulse");
    cmp(busy_a, 1'b0, "requester back to idle");
    @(posedge mclk_i);
    wext <= 1'b0;
    cyc(4);
  endtask : run_a

  // Every mode and style, exact wait-state spacing, dynamic extension
  task automatic t_access;
    int n0, n5, i;
    for (i = 0; i < 4; i++) begin
      run_a(i[0], i[1], 3'h0, 1'b0, 11'h2a5, n0);
      run_a(i[0], i[1], 3'h5, 1'b0, 11'h15a, n5);
      cmp(n5 - n0, 16'h5, "programmed wait states");
    end
    run_a(1'b1, 1'b1, 3'h0, 1'b1, 11'h7ff, n5);
    cmp(n5 > n0, 1'b1, "extension adds cycles");
    $display("test access done");
  endtask : t_access

  // Second port: alone, then queued behind a first-port access
  task automatic t_port_b(input logic behind_a);
    int k, ta, tb;
    ta = -1;
    tb = -1;
    @(posedge mclk_i);
    start_a <= behind_a;
    @(posedge mclk_i);
    start_a <= 1'b0;
    start_b <= 1'b1;
    @(posedge mclk_i);
    start_b <= 1'b0;
    for (k = 0; k < 200; k++) begin
      cyc(1);
      if (ras_n === 1'b0 && pb_act !== 1'b1 && ta < 0) ta = k;
      if (pb_act === 1'b1 && tb < 0) begin
        tb = k;
        cmp(link.second_port_early_ack_n, 1'b0, "early ack with b strobe");
        cmp(ras_n, 1'b0, "b strobe low");
      end
      if (ta >= 0 && tb < 0 && ras_n === 1'b0) begin
        cmp(link.second_port_granted, 1'b0, "grant low while a owns");
      end
      if (rf_act === 1'b1 && pb_act === 1'b1) cmp(1'b0, 1'b1, "two owners");
    end
    cmp(tb >= 0, 1'b1, "b request registered");
    cmp(behind_a ? (ta >= 0 && tb > ta) : (ta < 0), 1'b1, "b waits for a");
    cmp(link.second_port_granted, 1'b1, "grant held by b");
    cmp(gnt, 1'b1, "grant seen by requester");
    cmp(busy_b, 1'b0, "port b requester released");
    $display("test port b done");
  endtask : t_port_b

  // Burst of external refreshes, then row counter clear
  task automatic t_refresh;
    int k, nref, n1;
    logic prev;
    logic [10:0] r0;
    nref = 0;
    prev = 1'b0;
    r0 = rf_row;
    @(posedge mclk_i);
    rreq <= 1'b1;
    for (k = 0; k < 200; k++) begin
      if (k == 140) n1 = nref;
      @(posedge mclk_i);
      if (k == 100) rreq <= 1'b0;
      #1;
      if (rf_act === 1'b1 && !prev) nref++;
      prev = rf_act;
    end
    cmp(nref >= 3, 1'b1, "burst of refreshes");
    cmp(nref, n1, "burst stops on release");
    cmp(rf_row, r0 + nref[10:0], "row advanced per refresh");
    @(posedge mclk_i);
    xmode <= 1'b0;
    rclr <= 1'b1;
    cyc(10);
    @(posedge mclk_i);
    rclr <= 1'b0;
    xmode <= 1'b1;
    cyc(8);
    cmp(rf_row, 11'h0, "row counter cleared");
    $display("test refresh done");
  endtask : t_refresh

  // Due interval with internal refresh suppressed, then internal refresh
  task automatic t_due;
    int k, t0, t1, nref;
    logic prev;
    t0 = -1;
    t1 = -1;
    nref = 0;
    prev = 1'b0;
    @(posedge mclk_i);
    rout <= 1'b1;
    for (k = 0; k < 7000; k++) begin
      cyc(1);
      if (rf_act === 1'b1 && !prev) nref++;
      prev = rf_act;
      if (due === 1'b1 && t0 < 0) t0 = k;
      else if (due === 1'b1 && t1 < 0) t1 = k;
    end
    cmp(t1 - t0, `VRPA_EXT_REFRESH_REQ_SHORT_CYC, "due interval");
    cmp(nref, 16'h0, "no internal refresh while disabled");
    @(posedge mclk_i);
    rout <= 1'b0;
    xmode <= 1'b0;
    for (k = 0; k < 3400 && rf_act !== 1'b1; k++) cyc(1);
    cmp(rf_act, 1'b1, "internal refresh runs when enabled");
    $display("test due done");
  endtask : t_due

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // Main sequence; refresh disabled until its own tests to keep counts clean
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    cyc(4);
    t_access();
    t_port_b(1'b0);
    t_port_b(1'b1);
    t_refresh();
    t_due();
    close_out();
  end

  // Watchdog, well beyond the roughly 10k cycles the tests need
  initial begin
    repeat (40000) @(posedge mclk_i);
    err_total++;
    $display("BAD t=%0t watchdog expired", $time);
    close_out();
  end
endmodule : vram_refresh_port_access_test

/* vrpa_ctrl.sv */
// VRAM controller front end: refresh requests, first-port access, second port.
// Assumes link pins are asynchronous to mclk_i; config inputs are on mclk_i.
// Overview of operation
// - External request with refresh disabled runs a refresh.
// - Held external request repeats refreshes back to back.
// - External request with refresh enabled clears row counter.
// - Refresh disable stops internal refresh; requester holds it.
// - Mode 0 latch enable plus select sets latch.
// - Set latch starts access at next clock edge.
// - Mode 1 strobe plus select starts row strobe.
// - Busy array delays mode 1 row strobe.
// - Strobe falling edge captures address when enabled.
// - No chip select, no first-port access.
// - Mode 0 request comes after first edge.
// - Mode 1 request precedes strobe release.
// - Negated request ends access, drops row strobe.
// - Wait style: output low while waiting.
// - Acknowledge style: output low when done.
// - Programmed edges delay wait/acknowledge transition.
// - Wait extend input adds edges.
// - Second-port request captures address, registers request.
// - Second-port row strobe now or when free.
// - Early acknowledge follows second-port row strobe.
// - Refresh due output pulses each interval.
// - Grant rises when second port takes array, stays high until first port does.
`timescale 1ns/1ps
`include "vrpa_map.svh"
module vrpa_ctrl #(
  parameter int WAIT_W = `VRPA_WAIT_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Link to requester
  vrpa_link_if.dev link,
  // Programmed mode bits
  input wire logic access_mode_i,
  input wire logic wait_style_sel_i,
  input wire logic addr_latch_en_i,
  input wire logic [WAIT_W-1:0] wait_states_i,
  input wire logic refresh_out_mode_i,
  input wire logic refresh_short_i,
  // Array side
  output logic ras_n_o,
  output logic refresh_active_o,
  output logic port_b_active_o,
  output logic [`VRPA_ROW_W-1:0] refresh_row_o,
  output logic [`VRPA_BANK_W-1:0] lat_bank_o,
  output logic [`VRPA_ROW_W-1:0] lat_row_o,
  output logic [`VRPA_COL_W-1:0] lat_col_o
);
  localparam int AW = `VRPA_BANK_W + `VRPA_ROW_W + `VRPA_COL_W;
  localparam int SW = 7 + AW;
  localparam logic [SW-1:0] SYNC_RST = {`VRPA_DEV_PIN_RST, {AW{1'h0}}};
  localparam logic [`VRPA_ICNT_W-1:0] LONG_LIM = `VRPA_ICNT_W'(`VRPA_EXT_REFRESH_REQ_LONG_CYC - 1);
  localparam logic [`VRPA_ICNT_W-1:0] SHORT_LIM = `VRPA_ICNT_W'(`VRPA_EXT_REFRESH_REQ_SHORT_CYC - 1);
  localparam logic [`VRPA_RCNT_W-1:0] RAS_LIM = `VRPA_RCNT_W'(`VRPA_EXT_REFRESH_REQ_RAS_CYC - 1);

  vrpa_pkg::vrpa_state_e state_r, state_nxt;
  logic strb_prev_r, breq_prev_r;
  logic a_pend_r, b_pend_r, int_pend_r;
  logic access_req_n_seen_r, ack_done_r;
  logic [WAIT_W-1:0] wcnt_r;
  logic [`VRPA_ICNT_W-1:0] icnt_r;
  logic [`VRPA_RCNT_W-1:0] rcnt_r;
  logic [`VRPA_ROW_W-1:0] rrow_r;
  logic [AW-1:0] lat_r;
  logic ras_n_r, xfer_ack_n_r, early_ack_n_r, due_n_r, grant_r;
  wire [SW-1:0] sync_in;
  wire [SW-1:0] sync_w;

  // All link pins cross in; addresses ride the same two stages
  assign sync_in = {link.ext_refresh_req_n, link.refresh_disable_n, link.addr_strobe_n,
                    link.chip_sel_n, link.access_req_n, link.wait_extend,
                    link.second_port_req_n, link.bank, link.row, link.col};

  // Two-stage synchroniser per pin bit
  for (genvar i = 0; i < SW; i++) begin : g_sync
    logic m_r, s_r;
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        m_r <= SYNC_RST[i];
        s_r <= SYNC_RST[i];
      end else begin
        m_r <= sync_in[i];
        s_r <= m_r;
      end
    end
    assign sync_w[i] = s_r;
  end

  // Decoded pins, asserted high
  wire ext_req_w = ~sync_w[SW-1];
  wire dis_w = ~sync_w[SW-2];
  wire strb_hi_w = sync_w[SW-3];
  wire cs_w = ~sync_w[SW-4];
  wire access_req_n_w = ~sync_w[SW-5];
  wire wext_w = sync_w[SW-6];
  wire breq_w = ~sync_w[SW-7];
  wire [AW-1:0] addr_w = sync_w[AW-1:0];

  // Strobe and request edges
  wire strb_fall_w = strb_prev_r & ~strb_hi_w;
  wire ale_rise_w = ~strb_prev_r & strb_hi_w;
  wire a_start_w = cs_w & (access_mode_i ? strb_fall_w : ale_rise_w);
  wire b_start_w = breq_w & ~breq_prev_r;
  wire cap_w = ~addr_latch_en_i | strb_fall_w | b_start_w;

  // Refresh interval and request terms
  wire [`VRPA_ICNT_W-1:0] ilim_w = refresh_short_i ? SHORT_LIM : LONG_LIM;
  wire tick_w = (icnt_r == ilim_w);
  wire ext_ext_refresh_req_w = ext_req_w & dis_w;
  wire row_clr_w = ext_req_w & ~dis_w;
  wire ext_refresh_req_go_w = int_pend_r | ext_ext_refresh_req_w;
  wire wait_hit_w = (wcnt_r == wait_states_i);
  wire ext_refresh_req_end_w = (rcnt_r == RAS_LIM);
  wire a_end_w = access_req_n_seen_r & ~access_req_n_w;
  wire enter_a_w = (state_nxt == vrpa_pkg::VRPA_ST_ACCA) & (state_r != vrpa_pkg::VRPA_ST_ACCA);
  wire enter_b_w = (state_nxt == vrpa_pkg::VRPA_ST_ACCB) & (state_r != vrpa_pkg::VRPA_ST_ACCB);
  wire enter_r_w = (state_nxt == vrpa_pkg::VRPA_ST_EXT_REFRESH_REQ) & (state_r != vrpa_pkg::VRPA_ST_EXT_REFRESH_REQ);
  wire in_a_w = (state_r == vrpa_pkg::VRPA_ST_ACCA);
  wire waiting_w = a_pend_r | (in_a_w & ~ack_done_r);
  wire done_w = in_a_w & ack_done_r;

  // Array arbiter: refresh first, then first port, then second port
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      vrpa_pkg::VRPA_ST_IDLE: begin
        if (ext_refresh_req_go_w) begin
          state_nxt = vrpa_pkg::VRPA_ST_EXT_REFRESH_REQ;
        end else if (a_pend_r | a_start_w) begin
          state_nxt = vrpa_pkg::VRPA_ST_ACCA;
        end else if (b_pend_r | b_start_w) begin
          state_nxt = vrpa_pkg::VRPA_ST_ACCB;
        end
      end
      vrpa_pkg::VRPA_ST_EXT_REFRESH_REQ: begin
        if (ext_refresh_req_end_w) begin
          state_nxt = vrpa_pkg::VRPA_ST_IDLE;
        end
      end
      vrpa_pkg::VRPA_ST_ACCA: begin
        if (a_end_w) begin
          state_nxt = vrpa_pkg::VRPA_ST_IDLE;
        end
      end
      vrpa_pkg::VRPA_ST_ACCB: begin
        if (~breq_w) begin
          state_nxt = vrpa_pkg::VRPA_ST_IDLE;
        end
      end
      default: state_nxt = vrpa_pkg::VRPA_ST_IDLE;
    endcase
  end

  // State, edge history and pending requests; a new request beats its clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= vrpa_pkg::VRPA_ST_IDLE;
      strb_prev_r <= 1'h1;
      breq_prev_r <= 1'h0;
      a_pend_r <= 1'h0;
      b_pend_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      strb_prev_r <= strb_hi_w;
      breq_prev_r <= breq_w;
      // A request taken straight into its access must not stay pending
      a_pend_r <= enter_a_w ? (a_pend_r & a_start_w) : (a_pend_r | a_start_w);
      b_pend_r <= enter_b_w ? (b_pend_r & b_start_w) : (b_pend_r | b_start_w);
    end
  end

  // Interval timer and internal refresh pending
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      icnt_r <= '0;
      int_pend_r <= 1'h0;
      due_n_r <= 1'h1;
    end else begin
      icnt_r <= tick_w ? '0 : icnt_r + 1'h1;
      int_pend_r <= (tick_w & ~dis_w) | (int_pend_r & ~enter_r_w & ~dis_w);
      due_n_r <= ~(tick_w & refresh_out_mode_i);
    end
  end

  // Refresh row strobe timing and refresh row counter
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rcnt_r <= '0;
      rrow_r <= '0;
    end else begin
      rcnt_r <= (state_r == vrpa_pkg::VRPA_ST_EXT_REFRESH_REQ) ? rcnt_r + 1'h1 : '0;
      if (row_clr_w) begin
        rrow_r <= '0;
      end else if ((state_r == vrpa_pkg::VRPA_ST_EXT_REFRESH_REQ) & ext_refresh_req_end_w) begin
        rrow_r <= rrow_r + 1'h1;
      end
    end
  end

  // Wait-state count for first-port accesses
  always_ff @(posedge mclk_i) begin
    if (rst_i | ~in_a_w) begin
      wcnt_r <= '0;
      ack_done_r <= 1'h0;
      access_req_n_seen_r <= 1'h0;
    end else begin
      access_req_n_seen_r <= access_req_n_seen_r | access_req_n_w;
      if (~ack_done_r & ~wext_w) begin
        ack_done_r <= wait_hit_w;
        wcnt_r <= wait_hit_w ? wcnt_r : wcnt_r + 1'h1;
      end
    end
  end

  // Address latch; flows through when latching is off
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lat_r <= '0;
    end else if (cap_w) begin
      lat_r <= addr_w;
    end
  end

  // Registered pins toward array and requester
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ras_n_r <= 1'h1;
      early_ack_n_r <= 1'h1;
      grant_r <= 1'h0;
      xfer_ack_n_r <= 1'h1;
    end else begin
      ras_n_r <= (state_nxt == vrpa_pkg::VRPA_ST_IDLE);
      early_ack_n_r <= (state_nxt != vrpa_pkg::VRPA_ST_ACCB);
      if (enter_b_w) begin
        grant_r <= 1'h1;
      end else if (enter_a_w) begin
        grant_r <= 1'h0;
      end
      xfer_ack_n_r <= wait_style_sel_i ? ~done_w : ~waiting_w;
    end
  end

  assign link.xfer_ack_n = xfer_ack_n_r;
  assign link.second_port_early_ack_n = early_ack_n_r;
  assign link.refresh_due_n = due_n_r;
  assign link.second_port_granted = grant_r;
  assign ras_n_o = ras_n_r;
  assign refresh_active_o = state_r[1]; // One-hot bit, no decode after the flop
  assign port_b_active_o = state_r[3];
  assign refresh_row_o = rrow_r;
  assign {lat_bank_o, lat_row_o, lat_col_o} = lat_r;
endmodule : vrpa_ctrl

/* vrpa_link_asserts.sv */
// Concurrent checks on the pins between controller and requester.
// Assumes both ends share mclk_i and a synchronous active-high rst_i.
`timescale 1ns/1ps
module vrpa_link_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Requester driven pins
  input wire logic chip_sel_n,
  input wire logic access_req_n,
  input wire logic second_port_req_n,
  // Controller driven pins
  input wire logic xfer_ack_n,
  input wire logic second_port_early_ack_n,
  input wire logic refresh_due_n,
  input wire logic second_port_granted
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Cycles since the last due pulse, saturating so it never wraps
  logic [12:0] gap_r;
  logic [12:0] gap_nxt;
  assign gap_nxt = !refresh_due_n ? 13'h0 : ((gap_r == 13'h1fff) ? gap_r : gap_r + 13'h1);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      gap_r <= 13'h0;
    end else begin
      gap_r <= gap_nxt;
    end
  end

  // Steps of a second-port transfer
  sequence b_req_fall;
    $fell(second_port_req_n);
  endsequence
  sequence b_ack_fall;
    $fell(second_port_early_ack_n);
  endsequence

  // Second-port request must be served even behind a busy array
  chk_b_req_served: assert property (b_req_fall |-> ##[1:100] b_ack_fall)
    else $error("second port request never acknowledged");
  chk_b_ack_release: assert property ($rose(second_port_req_n) |-> ##[1:5] second_port_early_ack_n)
    else $error("early ack held after second port release");
  chk_b_ack_grant: assert property (b_ack_fall |-> ##[0:2] second_port_granted)
    else $error("early ack without grant");
  chk_grant_rise_b: assert property ($rose(second_port_granted) |-> ##[0:2] !second_port_early_ack_n)
    else $error("grant rose without a second port access");
  chk_due_one_cycle: assert property ($fell(refresh_due_n) |=> refresh_due_n)
    else $error("refresh due pulse longer than one cycle");
  chk_due_interval_min: assert property ($fell(refresh_due_n) |-> gap_r >= 13'hca8)
    else $error("refresh due pulses too close");
  chk_reset_idle_pins: assert property ($fell(rst_i) |-> xfer_ack_n && second_port_early_ack_n
      && refresh_due_n && !second_port_granted)
    else $error("controller pins not idle after reset");
  chk_req_with_select: assert property (!access_req_n |-> !chip_sel_n)
    else $error("access request without chip select");
endmodule : vrpa_link_asserts

/* vrpa_link_if.sv */
// Pin bundle between the VRAM controller and its requester.
// Assumes both ends run from the same mclk_i but sample pins as foreign.
`timescale 1ns/1ps
`include "vrpa_map.svh"
interface vrpa_link_if;
  logic ext_refresh_req_n;
  logic refresh_disable_n;
  logic addr_strobe_n;
  logic chip_sel_n;
  logic access_req_n;
  logic wait_extend;
  logic second_port_req_n;
  logic [`VRPA_BANK_W-1:0] bank;
  logic [`VRPA_ROW_W-1:0] row;
  logic [`VRPA_COL_W-1:0] col;
  logic xfer_ack_n;
  logic second_port_early_ack_n;
  logic refresh_due_n;
  logic second_port_granted;
  modport dev (
    input ext_refresh_req_n, refresh_disable_n, addr_strobe_n, chip_sel_n,
    input access_req_n, wait_extend, second_port_req_n, bank, row, col,
    output xfer_ack_n, second_port_early_ack_n, refresh_due_n, second_port_granted
  );
  modport req (
    output ext_refresh_req_n, refresh_disable_n, addr_strobe_n, chip_sel_n,
    output access_req_n, wait_extend, second_port_req_n, bank, row, col,
    input xfer_ack_n, second_port_early_ack_n, refresh_due_n, second_port_granted
  );
endinterface : vrpa_link_if

/* vrpa_map.svh */
// Constants shared by both ends of the VRAM port/refresh link.
// Assumes a 250 MHz clock on both ends.
`ifndef VRPA_MAP_SVH
`define VRPA_MAP_SVH
// Address field widths
`define VRPA_BANK_W 2
`define VRPA_ROW_W 11
`define VRPA_COL_W 11
// Wait-state count field width
`define VRPA_WAIT_W 3
// Clock period and timing figures
`define VRPA_CLK_NS 4
`define VRPA_EXT_REFRESH_REQ_LONG_US 15
`define VRPA_EXT_REFRESH_REQ_SHORT_US 13
`define VRPA_EXT_REFRESH_REQ_RAS_NS 80
`define VRPA_EXT_REFRESH_REQ_LONG_CYC ((`VRPA_EXT_REFRESH_REQ_LONG_US * 1000) / `VRPA_CLK_NS)
`define VRPA_EXT_REFRESH_REQ_SHORT_CYC ((`VRPA_EXT_REFRESH_REQ_SHORT_US * 1000) / `VRPA_CLK_NS)
`define VRPA_EXT_REFRESH_REQ_RAS_CYC ((`VRPA_EXT_REFRESH_REQ_RAS_NS + `VRPA_CLK_NS - 1) / `VRPA_CLK_NS)
`define VRPA_ICNT_W 12
`define VRPA_RCNT_W 5
// Requester hold time of a second-port access
`define VRPA_B_HOLD 4
`define VRPA_BCNT_W 4
// Idle levels of the synchronised pins
`define VRPA_DEV_PIN_RST 7'h7d
`define VRPA_REQ_PIN_RST 4'he
`endif

/* vrpa_pkg.sv */
// Types shared by both ends of the VRAM port/refresh link.
// Assumes vrpa_map.svh supplies the numbers.
package vrpa_pkg;
  // Controller array states
  typedef enum logic [3:0] {
    VRPA_ST_IDLE = 4'h1,
    VRPA_ST_EXT_REFRESH_REQ = 4'h2,
    VRPA_ST_ACCA = 4'h4,
    VRPA_ST_ACCB = 4'h8
  } vrpa_state_e;
  // Requester first-port states
  typedef enum logic [4:0] {
    VRPA_H_IDLE = 5'h01,
    VRPA_H_SETUP = 5'h02,
    VRPA_H_STRB = 5'h04,
    VRPA_H_WAIT = 5'h08,
    VRPA_H_END = 5'h10
  } vrpa_hstate_e;
endpackage : vrpa_pkg

/* vrpa_req.sv */
// Requester end: drives first-port, second-port and refresh pins.
// Assumes controller outputs are asynchronous; user inputs are on mclk_i.
`timescale 1ns/1ps
`include "vrpa_map.svh"
module vrpa_req (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Link to controller
  vrpa_link_if.req link,
  // Mode copies, must match controller programming
  input wire logic access_mode_i,
  input wire logic wait_style_sel_i,
  // First-port request
  input wire logic start_a_i,
  input wire logic [`VRPA_BANK_W-1:0] bank_i,
  input wire logic [`VRPA_ROW_W-1:0] row_i,
  input wire logic [`VRPA_COL_W-1:0] col_i,
  input wire logic wait_extend_i,
  output logic busy_a_o,
  output logic done_a_o,
  // Second-port request
  input wire logic start_b_i,
  output logic busy_b_o,
  // Refresh control and second-port grant
  input wire logic ext_refresh_mode_i,
  input wire logic refresh_req_i,
  input wire logic row_clear_i,
  output logic refresh_due_o,
  output logic granted_b_o
);
  localparam logic [3:0] SYNC_RST = `VRPA_REQ_PIN_RST;
  localparam logic [`VRPA_BCNT_W-1:0] B_HOLD = `VRPA_BCNT_W'(`VRPA_B_HOLD);

  vrpa_pkg::vrpa_hstate_e hst_r;
  logic cs_n_r, strb_n_r, access_req_n_n_r, done_r, seen_wait_r;
  logic breq_n_r, bbusy_r, wext_r, ext_n_r, dis_n_r;
  logic [`VRPA_BCNT_W-1:0] bcnt_r;
  logic [`VRPA_BANK_W+`VRPA_ROW_W+`VRPA_COL_W-1:0] addr_r;
  wire [3:0] sync_in;
  wire [3:0] sync_w;

  assign sync_in = {link.xfer_ack_n, link.second_port_early_ack_n,
                    link.refresh_due_n, link.second_port_granted};

  // Two-stage synchroniser per controller output
  for (genvar i = 0; i < 4; i++) begin : g_sync
    logic m_r, s_r;
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        m_r <= SYNC_RST[i];
        s_r <= SYNC_RST[i];
      end else begin
        m_r <= sync_in[i];
        s_r <= m_r;
      end
    end
    assign sync_w[i] = s_r;
  end

  // Wait or acknowledge reading depends on the output style
  wire ack_lo_w = ~sync_w[3];
  wire wait_seen_w = wait_style_sel_i | ack_lo_w;
  wire done_seen_w = seen_wait_r & (wait_style_sel_i ? ack_lo_w : ~ack_lo_w);
  wire eack_w = ~sync_w[2];

  // First-port sequence: select, strobe, request, wait, release
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hst_r <= vrpa_pkg::VRPA_H_IDLE;
      cs_n_r <= 1'h1;
      strb_n_r <= 1'h1;
      access_req_n_n_r <= 1'h1;
      done_r <= 1'h0;
      seen_wait_r <= 1'h0;
      addr_r <= '0;
    end else begin
      done_r <= 1'h0;
      case (hst_r)
        vrpa_pkg::VRPA_H_IDLE: begin
          strb_n_r <= 1'h1; // mode 0 idles low below
          if (~access_mode_i) begin
            strb_n_r <= 1'h0;
          end
          if (start_a_i) begin
            addr_r <= {bank_i, row_i, col_i};
            cs_n_r <= 1'h0;
            hst_r <= vrpa_pkg::VRPA_H_SETUP;
          end
        end
        vrpa_pkg::VRPA_H_SETUP: begin
          strb_n_r <= ~access_mode_i;
          hst_r <= vrpa_pkg::VRPA_H_STRB;
        end
        vrpa_pkg::VRPA_H_STRB: begin
          access_req_n_n_r <= 1'h0;
          if (~access_mode_i) begin
            strb_n_r <= 1'h0;
          end
          seen_wait_r <= 1'h0;
          hst_r <= vrpa_pkg::VRPA_H_WAIT;
        end
        vrpa_pkg::VRPA_H_WAIT: begin
          strb_n_r <= access_mode_i;
          seen_wait_r <= seen_wait_r | wait_seen_w;
          if (done_seen_w) begin
            hst_r <= vrpa_pkg::VRPA_H_END;
          end
        end
        vrpa_pkg::VRPA_H_END: begin
          access_req_n_n_r <= 1'h1;
          cs_n_r <= 1'h1;
          done_r <= 1'h1;
          hst_r <= vrpa_pkg::VRPA_H_IDLE;
        end
        default: hst_r <= vrpa_pkg::VRPA_H_IDLE;
      endcase
    end
  end

  // Second port: hold request a fixed time after early acknowledge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      breq_n_r <= 1'h1;
      bbusy_r <= 1'h0;
      bcnt_r <= '0;
    end else if (~bbusy_r) begin
      bcnt_r <= '0;
      if (start_b_i) begin
        breq_n_r <= 1'h0;
        bbusy_r <= 1'h1;
      end
    end else if (eack_w & ~breq_n_r) begin
      bcnt_r <= bcnt_r + 1'h1;
      if (bcnt_r == B_HOLD) begin
        breq_n_r <= 1'h1;
      end
    end else if (breq_n_r & ~eack_w) begin
      bbusy_r <= 1'h0; // release seen by controller
    end
  end

  // Refresh pins; disable is held whenever external refresh is asked
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ext_n_r <= 1'h1;
      dis_n_r <= 1'h1;
      wext_r <= 1'h0;
    end else begin
      dis_n_r <= ~ext_refresh_mode_i;
      ext_n_r <= ~(ext_refresh_mode_i ? refresh_req_i : row_clear_i);
      wext_r <= wait_extend_i;
    end
  end

  assign link.chip_sel_n = cs_n_r;
  assign link.addr_strobe_n = strb_n_r;
  assign link.access_req_n = access_req_n_n_r;
  assign link.wait_extend = wext_r;
  assign link.second_port_req_n = breq_n_r;
  assign link.ext_refresh_req_n = ext_n_r;
  assign link.refresh_disable_n = dis_n_r;
  assign {link.bank, link.row, link.col} = addr_r;
  assign busy_a_o = (hst_r != vrpa_pkg::VRPA_H_IDLE);
  assign done_a_o = done_r;
  assign busy_b_o = bbusy_r;
  assign refresh_due_o = ~sync_w[1];
  assign granted_b_o = sync_w[0];
endmodule : vrpa_req
